/* File: hdl/udmaf_pkg.sv */
// What this block does
// - eleven low bit times set break flag
// - eleven bits cover whole frame plus stop
// - break flag sticky until clear or reset
// - break with uart and reset enable requests programming reset
// - double buffer gives back-to-back frames, one stop
// - double buffer off means single-buffered transmit
// - empty buffer write loads shifter, interrupts now if double buffered
// - last char interrupt at stop start/end
// - queued write interrupts at stop start/end
// - write racing final stop resolved deterministically
// - double buffer captures ninth bit with data
// - nine-bit modes store received ninth bit
// - filter on: receive only when ninth is one
// - filter ignored in mode 0, off mode 1
// - error select 0, filter on: flag during ninth bit
// - error select 1: flag during stop bit
// - filter accepts only given or broadcast address
// - given address is masked match value
// - broadcast address is value or mask ones
// - match value and mask reset to zero
// - bit value is majority of phases 7-9
// - accept only if flag clear and filter passes
// - missing stop bit sets sticky frame error unless filter on, ninth zero and select 1
package udmaf_pkg;

  localparam logic [3:0] PH_S1      = 4'h7;
  localparam logic [3:0] PH_S2      = 4'h8;
  localparam logic [3:0] PH_S3      = 4'h9;
  localparam logic [3:0] PH_LAST    = 4'hF;
  localparam logic [3:0] BREAK_BITS = 4'hB;
  localparam logic [3:0] LAST_DATA8 = 4'h7;
  localparam logic [3:0] LAST_DATA9 = 4'h8;
  localparam logic [1:0] MODE_SYNC  = 2'h0;
  localparam logic [7:0] MATCH_RST  = 8'h00;

  typedef enum logic [1:0] {RX_IDLE, RX_START, RX_DATA, RX_STOP} udmaf_rx_st_t;
  typedef enum logic [2:0] {TX_IDLE, TX_START, TX_DATA, TX_NINTH, TX_STOP}
    udmaf_tx_st_t;

  typedef struct packed {
    logic [1:0] mode;
    logic       uart_enable;
    logic       tx_double_buffer_enable;
    logic       last_char_irq_select;
    logic       tx_irq_at_stop_end;
    logic       addr_filter_enable;
    logic       error_bit_select;
    logic       break_reset_enable;
  } udmaf_cfg_t;

  typedef struct packed {
    logic       ninth;
    logic [7:0] data;
  } udmaf_rx_word_t;

  function automatic logic udmaf_maj3(input logic a, input logic b,
                                      input logic c);
    return (a & b) | (a & c) | (b & c);
  endfunction

  function automatic logic udmaf_addr_match(input logic [7:0] rx,
                                            input logic [7:0] val,
                                            input logic [7:0] mask);
    logic given;
    logic bcast;
    given = (((rx ^ val) & mask) == 8'h00);
    bcast = (((val | mask) & ~rx) == 8'h00);
    return given | bcast;
  endfunction

endpackage

/* File: hdl/udmaf_skid2.sv */
`timescale 1ns/1ns
module udmaf_skid2 #(
  parameter int unsigned W = 9
) (
  input  wire logic         i_core_clk,
  input  wire logic         i_reset,
  input  wire logic         i_in_valid,
  output logic              o_in_ready,
  input  wire logic [W-1:0] i_in_data,
  output logic              o_out_valid,
  input  wire logic         i_out_ready,
  output logic      [W-1:0] o_out_data
);
  typedef struct packed {
    logic [1:0][W-1:0] mem;
    logic              wp;
    logic              rp;
    logic [1:0]        cnt;
  } udmaf_sk_st_t;

  udmaf_sk_st_t q;
  udmaf_sk_st_t n;
  logic         push;
  logic         pop;

  assign o_in_ready  = (q.cnt != 2'h2);
  assign o_out_valid = (q.cnt != 2'h0);
  assign o_out_data  = q.mem[q.rp];
  assign push        = i_in_valid && o_in_ready;
  assign pop         = o_out_valid && i_out_ready;

  always_comb begin
    n = q;
    if (push) begin
      n.mem[q.wp] = i_in_data;
      n.wp        = ~q.wp;
    end
    if (pop) begin
      n.rp = ~q.rp;
    end
    if (push && !pop) begin
      n.cnt = q.cnt + 2'h1;
    end else if (pop && !push) begin
      n.cnt = q.cnt - 2'h1;
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (i_reset) begin
      q <= '0;
    end else begin
      q <= n;
    end
  end

  default clocking @(posedge i_core_clk); endclocking
  default disable iff (i_reset);

  chk_fifo_no_lost_word: assert property (
    push && !pop && q.cnt == 2'h1 |=> !o_in_ready)
    else $error("two-entry buffer did not fill");
endmodule

/* File: hdl/udmaf_uart.sv */
`timescale 1ns/1ns
module udmaf_uart
  import udmaf_pkg::*;
(
  input  wire logic           i_core_clk,
  input  wire logic           i_reset,
  input  wire logic           i_baud16_tick,
  input  udmaf_cfg_t          i_cfg,
  input  wire logic           i_serial_buffer_wr,
  input  wire logic [7:0]     i_serial_buffer_wdata,
  input  wire logic           i_tx_ninth_bit,
  input  wire logic           i_match_wr,
  input  wire logic [7:0]     i_slave_match_value,
  input  wire logic [7:0]     i_slave_match_mask,
  input  wire logic           i_clr_receive_done,
  input  wire logic           i_clr_frame_error,
  input  wire logic           i_clr_line_low,
  input  wire logic           i_rxd,
  output logic                o_txd,
  output logic                o_tx_irq,
  output logic                o_tx_busy,
  output logic                o_tx_buffer_full,
  output logic                o_receive_done_flag,
  output logic                o_frame_error_flag,
  output logic                o_line_low_detect_flag,
  output logic                o_rx_ninth_bit,
  output logic                o_isp_reset_req,
  output logic                o_rx_valid,
  input  wire logic           i_rx_ready,
  output udmaf_rx_word_t      o_rx_word
);
  typedef struct packed {
    logic [3:0]   rph;
    logic [1:0]   smp;
    logic         rx_prev;
    udmaf_rx_st_t rst;
    logic [3:0]   rbit;
    logic [8:0]   rsh;
    logic         early;
    logic         ri;
    logic         fe;
    logic         br;
    logic         rb8;
    logic [3:0]   blow;
    logic         armed;
    logic         in_system_programming;
    logic [7:0]   sval;
    logic [7:0]   smask;
    logic [3:0]   tph;
    udmaf_tx_st_t tst;
    logic [2:0]   tbit;
    logic [8:0]   tsh;
    logic [8:0]   tbuf;
    logic         tbuf_full;
    logic         owed;
    logic         txd;
    logic         tx_irq;
  } udmaf_st_t;

  udmaf_st_t      q;
  udmaf_st_t      n;
  logic           bit_done;
  logic           vbit;
  logic           filt;
  logic           nine;
  logic           wr;
  logic           tend;
  logic           stop_begin;
  logic           stop_end;
  logic           irq_point;
  logic           fifo_ready;
  logic           push;
  udmaf_rx_word_t push_word;

  assign bit_done   = i_baud16_tick && (q.rph == PH_S3);
  assign vbit       = udmaf_maj3(q.smp[1], q.smp[0], i_rxd);
  // filtering only exists in the nine-bit modes; ignored in mode 0
  assign filt       = i_cfg.addr_filter_enable && i_cfg.mode[1];
  assign nine       = i_cfg.mode[1];
  assign wr         = i_serial_buffer_wr && (i_cfg.mode != MODE_SYNC);
  assign tend       = i_baud16_tick && (q.tph == PH_LAST);
  assign stop_begin = tend && ((q.tst == TX_NINTH) ||
                      (q.tst == TX_DATA && q.tbit == 3'h7 && !nine));
  assign stop_end   = tend && (q.tst == TX_STOP);
  assign irq_point  = i_cfg.tx_irq_at_stop_end ? stop_end : stop_begin;

  always_comb begin
    n         = q;
    n.tx_irq  = 1'b0;
    n.in_system_programming     = 1'b0;
    n.rx_prev = i_rxd;
    push      = 1'b0;
    push_word = '0;
    // clears first so that a set in the same cycle wins
    if (i_clr_receive_done) begin
      n.ri = 1'b0;
    end
    if (i_clr_frame_error) begin
      n.fe = 1'b0;
    end
    if (i_clr_line_low) begin
      n.br = 1'b0;
    end
    if (i_match_wr) begin
      n.sval  = i_slave_match_value;
      n.smask = i_slave_match_mask;
    end
    // bit timer free-runs when idle so breaks are timed without a frame
    if (i_baud16_tick) begin
      n.rph = q.rph + 4'h1;
      if (q.rph == PH_S1 || q.rph == PH_S2) begin
        n.smp = {q.smp[0], i_rxd};
      end
    end
    unique case (q.rst)
      RX_IDLE: begin
        if (q.rx_prev && !i_rxd && i_cfg.mode != MODE_SYNC) begin
          n.rph = 4'h0;
          n.rst = RX_START;
        end
      end
      RX_START: begin
        if (bit_done) begin
          n.rst   = vbit ? RX_IDLE : RX_DATA;
          n.rbit  = 4'h0;
          n.early = 1'b0;
        end
      end
      RX_DATA: begin
        if (bit_done) begin
          n.rsh[q.rbit] = vbit;
          n.rbit        = q.rbit + 4'h1;
          if (q.rbit == (nine ? LAST_DATA9 : LAST_DATA8)) begin
            n.rst = RX_STOP;
          end
          if (nine && q.rbit == LAST_DATA9 && filt &&
              !i_cfg.error_bit_select) begin
            n.early = 1'b1;
            if (!q.ri && vbit && fifo_ready &&
                udmaf_addr_match(q.rsh[7:0], q.sval, q.smask)) begin
              n.ri      = 1'b1;
              n.rb8     = vbit;
              push      = 1'b1;
              push_word = {vbit, q.rsh[7:0]};
            end
          end
        end
      end
      RX_STOP: begin
        if (bit_done) begin
          n.rst = RX_IDLE;
          // no frame error for a frame with ninth bit zero under the filter when select is 1
          if (!vbit && !(filt && !q.rsh[8] && i_cfg.error_bit_select)) begin
            n.fe = 1'b1;
          end
          // in mode 1 the stop bit takes the ninth-bit place
          if (!q.early && !q.ri && fifo_ready && (!filt ||
              (q.rsh[8] && udmaf_addr_match(q.rsh[7:0], q.sval,
                                            q.smask)))) begin
            n.ri      = 1'b1;
            n.rb8     = nine ? q.rsh[8] : vbit;
            push      = 1'b1;
            push_word = {n.rb8, nine ? q.rsh[7:0] : q.rsh[7:0]};
          end
        end
      end
    endcase
    // break counter saturates so one long break sets the flag once
    if (bit_done) begin
      if (vbit) begin
        n.blow  = 4'h0;
        n.armed = 1'b1;
      end else if (q.blow != BREAK_BITS) begin
        n.blow = q.blow + 4'h1;
        if (q.blow == BREAK_BITS - 4'h1 && q.armed) begin
          n.br    = 1'b1;
          n.armed = 1'b0;
          n.in_system_programming   = i_cfg.uart_enable && i_cfg.break_reset_enable;
        end
      end
    end
    // transmitter
    if (q.tst != TX_IDLE && i_baud16_tick) begin
      n.tph = q.tph + 4'h1;
    end
    if (wr) begin
      if (q.tst == TX_IDLE && !q.tbuf_full) begin
        n.tsh    = {i_tx_ninth_bit, i_serial_buffer_wdata};
        n.tst    = TX_START;
        n.tph    = 4'h0;
        n.tx_irq = i_cfg.tx_double_buffer_enable;
      end else if (i_cfg.tx_double_buffer_enable) begin
        // no stall: a third write replaces the queued one
        n.tbuf      = {i_tx_ninth_bit, i_serial_buffer_wdata};
        n.tbuf_full = 1'b1;
        n.owed      = 1'b1;
      end
    end
    if (irq_point) begin
      if (!i_cfg.tx_double_buffer_enable) begin
        n.tx_irq = 1'b1;
      end else if (n.owed || (i_cfg.last_char_irq_select &&
                              !n.tbuf_full)) begin
        n.tx_irq = 1'b1;
        n.owed   = 1'b0;
      end
    end
    unique case (q.tst)
      TX_IDLE: begin
      end
      TX_START: begin
        if (tend) begin
          n.tst  = TX_DATA;
          n.tbit = 3'h0;
        end
      end
      TX_DATA: begin
        if (tend) begin
          n.tbit = q.tbit + 3'h1;
          if (q.tbit == 3'h7) begin
            n.tst = nine ? TX_NINTH : TX_STOP;
          end
        end
      end
      TX_NINTH: begin
        if (tend) begin
          n.tst = TX_STOP;
        end
      end
      TX_STOP: begin
        // a write in this very cycle counts as queued data
        if (tend) begin
          if (n.tbuf_full) begin
            n.tsh       = n.tbuf;
            n.tbuf_full = 1'b0;
            n.tst       = TX_START;
            n.tph       = 4'h0;
            if (n.owed) begin
              n.tx_irq = 1'b1;
              n.owed   = 1'b0;
            end
          end else begin
            n.tst = TX_IDLE;
          end
        end
      end
    endcase
    unique case (n.tst)
      TX_IDLE:  n.txd = 1'b1;
      TX_START: n.txd = 1'b0;
      TX_DATA:  n.txd = n.tsh[n.tbit];
      // single buffer reads the ninth bit live as it goes out
      TX_NINTH: n.txd = i_cfg.tx_double_buffer_enable ? n.tsh[8]
                                                       : i_tx_ninth_bit;
      TX_STOP:  n.txd = 1'b1;
    endcase
  end

  always_ff @(posedge i_core_clk) begin
    if (i_reset) begin
      q         <= '0;
      q.rx_prev <= 1'b1;
      q.armed   <= 1'b1;
      q.txd     <= 1'b1;
      q.sval    <= MATCH_RST;
      q.smask   <= MATCH_RST;
    end else begin
      q <= n;
    end
  end

  udmaf_skid2 #(
    .W (9)
  ) u_rx_buf (
    .i_core_clk  (i_core_clk),
    .i_reset     (i_reset),
    .i_in_valid  (push),
    .o_in_ready  (fifo_ready),
    .i_in_data   (push_word),
    .o_out_valid (o_rx_valid),
    .i_out_ready (i_rx_ready),
    .o_out_data  (o_rx_word)
  );

  assign o_txd                  = q.txd;
  assign o_tx_irq               = q.tx_irq;
  assign o_tx_busy              = (q.tst != TX_IDLE);
  assign o_tx_buffer_full       = q.tbuf_full;
  assign o_receive_done_flag    = q.ri;
  assign o_frame_error_flag     = q.fe;
  assign o_line_low_detect_flag = q.br;
  assign o_rx_ninth_bit         = q.rb8;
  assign o_isp_reset_req        = q.in_system_programming;

  default clocking @(posedge i_core_clk); endclocking
  default disable iff (i_reset);

  sequence s_stop_end_queued;
    stop_end && n.tbuf_full;
  endsequence
  sequence s_restart;
    q.tst == TX_START && !o_txd;
  endsequence

  chk_break_flag_set: assert property (
    bit_done && !vbit && q.blow == 4'hA && q.armed |=> o_line_low_detect_flag)
    else $error("break not flagged after eleven low bits");
  chk_break_sticky: assert property (
    o_line_low_detect_flag && !i_clr_line_low |=> o_line_low_detect_flag)
    else $error("break flag cleared by hardware");
  chk_isp_request: assert property (
    $rose(o_line_low_detect_flag) && $past(i_cfg.uart_enable) &&
    $past(i_cfg.break_reset_enable) |-> o_isp_reset_req)
    else $error("break reset request missing");
  chk_back_to_back: assert property (
    s_stop_end_queued |=> s_restart)
    else $error("queued character did not follow after one stop");
  chk_direct_load: assert property (
    wr && i_cfg.tx_double_buffer_enable && q.tst == TX_IDLE &&
    !q.tbuf_full |=> o_tx_irq && o_tx_busy ##1 !o_tx_irq)
    else $error("direct load did not interrupt at once");
  chk_no_last_irq: assert property (
    i_cfg.tx_double_buffer_enable && !i_cfg.last_char_irq_select &&
    irq_point && !q.owed && !wr |=> !o_tx_irq)
    else $error("spurious end of data interrupt");
  chk_single_irq: assert property (
    !i_cfg.tx_double_buffer_enable && irq_point |=> o_tx_irq)
    else $error("single buffer interrupt missing");
  chk_filter_ninth: assert property (
    filt && push |-> push_word.ninth)
    else $error("filtered frame accepted with ninth bit zero");
  chk_done_held: assert property (
    o_receive_done_flag && !i_clr_receive_done |=> o_receive_done_flag &&
    $stable(o_rx_ninth_bit))
    else $error("receive flag or ninth bit changed while set");
  chk_stop_frame_err: assert property (
    q.rst == RX_STOP && bit_done && !vbit && !filt |=> o_frame_error_flag)
    else $error("bad stop bit not flagged");
endmodule

/* File: tb/udmaf_node.sv */
`timescale 1ns/1ns
module udmaf_node (
  input  wire logic i_core_clk,
  input  wire logic i_tick,
  input  wire logic i_txd,
  output logic      o_rxd
);
  logic [8:0] got_q[$];
  time        start_q[$];
  int         bit_idx;

  initial begin
    o_rxd = 1'b1;
    bit_idx = 0;
  end

  task automatic ticks(input int n);
    repeat (n) begin
      @(posedge i_core_clk);
      while (i_tick !== 1'b1) @(posedge i_core_clk);
    end
  endtask

  task automatic drive(input logic v);
    #1 o_rxd = v;
    ticks(16);
  endtask

  // start, nine bits lsb first, stop; the line is pulled back high after
  task automatic send(input logic [8:0] w, input logic stop);
    bit_idx = 0;
    drive(1'b0);
    for (int i = 0; i < 9; i++) begin
      bit_idx = i + 1;
      drive(w[i]);
    end
    bit_idx = 10;
    drive(stop);
    bit_idx = 0;
    #1 o_rxd = 1'b1;
  endtask

  task automatic send_low(input int nbit);
    #1 o_rxd = 1'b0;
    ticks(16 * nbit);
    #1 o_rxd = 1'b1;
  endtask

  // samples mid-bit; a frame without a good stop bit is not recorded
  always begin
    logic [8:0] w;
    @(negedge i_txd);
    start_q.push_back($time);
    ticks(8);
    for (int i = 0; i < 9; i++) begin
      ticks(16);
      w[i] = i_txd;
    end
    ticks(16);
    if (i_txd === 1'b1) got_q.push_back(w);
  end
endmodule

/* File: tb/udmaf_uart_test.sv */
`timescale 1ns/1ns
module udmaf_uart_test
  import udmaf_pkg::*;
;
  logic           clk, reset, tick, wr, ninth, match_wr, rx_ready;
  logic           clr_rd, clr_fe, clr_ll, rxd, txd, irq, busy, full;
  logic           rdf, fef, llf, rxn, in_system_programming, rxv;
  logic     [7:0] wdata, mval, mmask;
  udmaf_cfg_t     cfg;
  udmaf_rx_word_t rx_word;
  int             err_total, num_checks, irq_cnt, isp_cnt;

  udmaf_uart dut (
    .i_core_clk(clk), .i_reset(reset), .i_baud16_tick(tick), .i_cfg(cfg),
    .i_serial_buffer_wr(wr), .i_serial_buffer_wdata(wdata),
    .i_tx_ninth_bit(ninth), .i_match_wr(match_wr),
    .i_slave_match_value(mval), .i_slave_match_mask(mmask),
    .i_clr_receive_done(clr_rd), .i_clr_frame_error(clr_fe),
    .i_clr_line_low(clr_ll), .i_rxd(rxd), .o_txd(txd), .o_tx_irq(irq),
    .o_tx_busy(busy), .o_tx_buffer_full(full), .o_receive_done_flag(rdf),
    .o_frame_error_flag(fef), .o_line_low_detect_flag(llf),
    .o_rx_ninth_bit(rxn), .o_isp_reset_req(in_system_programming), .o_rx_valid(rxv),
    .i_rx_ready(rx_ready), .o_rx_word(rx_word)
  );
  udmaf_node node (.i_core_clk(clk), .i_tick(tick), .i_txd(txd),
                   .o_rxd(rxd));

  initial clk = 1'b0;
  always #5 clk = ~clk;
  // tick every other cycle so a bit lasts 32 cycles and runs stay short
  always @(posedge clk) tick <= #1 ~tick;
  always @(posedge clk) begin
    if (irq === 1'b1) irq_cnt++;
    if (in_system_programming === 1'b1) isp_cnt++;
  end

  task automatic results;
    $display("checks %0d, mismatches %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  task automatic check(input string what, input logic [8:0] exp,
                       input logic [8:0] got);
    num_checks++;
    if (got !== exp) begin
      err_total++;
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task automatic tx_write(input logic [7:0] d, input logic n9);
    ninth = n9;
    wdata = d;
    wr = 1'b1;
    cyc(1);
    wr = 1'b0;
  endtask

  task automatic clr_all;
    clr_rd = 1'b1;
    clr_fe = 1'b1;
    clr_ll = 1'b1;
    cyc(1);
    clr_rd = 1'b0;
    clr_fe = 1'b0;
    clr_ll = 1'b0;
  endtask

  task automatic wait_got(input int n);
    for (int i = 0; i < 3000 && node.got_q.size() < n; i++) cyc(1);
    check("frames seen", 9'(n), 9'(node.got_q.size()));
  endtask

  // early holds the done flag as seen at the start of the stop bit
  task automatic rx_send(input logic [8:0] w, input logic stop,
                         output logic early);
    fork
      node.send(w, stop);
    join_none
    for (int i = 0; i < 9000 && node.bit_idx != 10; i++) @(posedge clk);
    check("stop reached", 9'd10, 9'(node.bit_idx));
    cyc(1);
    early = rdf;
    wait fork;
    cyc(4);
  endtask

  task automatic pop_check(input logic [8:0] exp);
    for (int i = 0; i < 50 && rxv !== 1'b1; i++) cyc(1);
    check("rx valid", 9'd1, {8'd0, rxv});
    check("rx word", exp, rx_word);
    rx_ready = 1'b1;
    cyc(1);
    rx_ready = 1'b0;
  endtask

  task automatic t_rx_filter;
    logic early;
    cfg.addr_filter_enable = 1'b1;
    cfg.error_bit_select = 1'b0;
    rx_send(9'h137, 1'b1, early);
    check("reset match", 9'd1, {8'd0, rdf});
    pop_check(9'h137);
    clr_all();
    mval = 8'hC0;
    mmask = 8'hFD;
    match_wr = 1'b1;
    cyc(1);
    match_wr = 1'b0;
    for (int e = 0; e < 2; e++) begin
      cfg.error_bit_select = e[0];
      rx_send(9'h1C2, 1'b1, early);
      check("flag at stop", {8'd0, e == 0}, {8'd0, early});
      check("given hit", 9'd1, {8'd0, rdf});
      check("ninth bit", 9'd1, {8'd0, rxn});
      pop_check(9'h1C2);
      clr_all();
      rx_send(9'h1C1, 1'b1, early);
      check("given miss", 9'd0, {8'd0, rdf});
      rx_send(9'h0C2, 1'b0, early);
      check("data byte", 9'd0, {8'd0, rdf});
      check("filtered error", {8'd0, e == 0}, {8'd0, fef});
      clr_all();
      rx_send(9'h1FD, 1'b1, early);
      check("broadcast hit", 9'd1, {8'd0, rdf});
      pop_check(9'h1FD);
      clr_all();
    end
  endtask

  // receiver stalls: the flag blocks one frame, the full buffer another
  task automatic t_rx_fill;
    logic early;
    cfg.addr_filter_enable = 1'b0;
    rx_send(9'h011, 1'b1, early);
    clr_all();
    rx_send(9'h122, 1'b1, early);
    rx_send(9'h033, 1'b1, early);
    clr_all();
    rx_send(9'h044, 1'b1, early);
    pop_check(9'h011);
    pop_check(9'h122);
    check("rx empty", 9'd0, {8'd0, rxv});
    cfg.mode = 2'h2;
    rx_send(9'h0AA, 1'b0, early);
    cyc(100);
    check("frame error", 9'd1, {8'd0, fef});
    clr_all();
    check("error cleared", 9'd0, {8'd0, fef});
    rx_ready = 1'b1;
    cyc(3);
    rx_ready = 1'b0;
    // eight-bit mode: the ninth slot of the node frame is the stop bit
    cfg.mode = 2'h1;
    rx_send(9'h15A, 1'b1, early);
    check("stop as ninth", 9'd1, {8'd0, rxn});
    pop_check(9'h15A);
    clr_all();
    cfg.mode = 2'h3;
  endtask

  task automatic t_tx_dbuf;
    logic [8:0] w1;
    time        gap;
    for (int k = 0; k < 3; k++) begin
      node.got_q.delete();
      node.start_q.delete();
      irq_cnt = 0;
      cfg.tx_double_buffer_enable = 1'b1;
      cfg.last_char_irq_select = (k != 0);
      cfg.tx_irq_at_stop_end = (k == 2);
      tx_write(8'hA5, 1'b1);
      cyc(3);
      check("first irq", 9'd1, irq_cnt[8:0]);
      tx_write(8'h3C, 1'b0);
      check("buffer full", 9'd1, {8'd0, full});
      cyc(1);
      if (k == 0) tx_write(8'h5A, 1'b1);
      w1 = (k == 0) ? 9'h15A : 9'h03C;
      wait_got(2);
      if (k != 0) check("irq mid stop", (k == 1) ? 9'd3 : 9'd2,
                        irq_cnt[8:0]);
      cyc(40);
      check("irq total", (k == 0) ? 9'd2 : 9'd3, irq_cnt[8:0]);
      check("tx word 0", 9'h1A5, node.got_q[0]);
      check("tx word 1", w1, node.got_q[1]);
      gap = node.start_q[1] - node.start_q[0];
      // the first start bit may lose one clock cycle to the tick phase
      check("one stop bit", 9'd1, {8'd0, gap >= 3510 && gap <= 3520});
    end
  endtask

  task automatic t_tx_single;
    node.got_q.delete();
    cfg.tx_double_buffer_enable = 1'b0;
    cfg.last_char_irq_select = 1'b0;
    tx_write(8'h81, 1'b0);
    check("tx busy", 9'd1, {8'd0, busy});
    ninth = 1'b1;
    cyc(5);
    tx_write(8'h42, 1'b1);
    wait_got(1);
    cyc(400);
    check("single count", 9'd1, 9'(node.got_q.size()));
    check("single word", 9'h181, node.got_q[0]);
    check("tx idle", 9'd0, {8'd0, busy});
    cfg.mode = 2'h0;
    tx_write(8'h55, 1'b0);
    check("sync write", 9'd0, {8'd0, busy});
    cfg.mode = 2'h3;
  endtask

  task automatic t_break;
    cfg.break_reset_enable = 1'b1;
    clr_all();
    isp_cnt = 0;
    node.send_low(10);
    cyc(40);
    check("short low", 9'd0, {8'd0, llf});
    node.send_low(14);
    cyc(40);
    check("break flag", 9'd1, {8'd0, llf});
    check("isp pulses", 9'd1, isp_cnt[8:0]);
    cyc(200);
    check("break sticky", 9'd1, {8'd0, llf});
    clr_all();
    check("break clear", 9'd0, {8'd0, llf});
  endtask

  initial begin
    reset = 1'b1;
    tick = 1'b0;
    wr = 1'b0;
    ninth = 1'b0;
    match_wr = 1'b0;
    rx_ready = 1'b0;
    clr_rd = 1'b0;
    clr_fe = 1'b0;
    clr_ll = 1'b0;
    wdata = 8'h00;
    mval = 8'h00;
    mmask = 8'h00;
    cfg = '0;
    cfg.mode = 2'h3;
    cfg.uart_enable = 1'b1;
    cyc(20);
    reset = 1'b0;
    check("idle line", 9'd1, {8'd0, txd});
    check("flags", 9'd0, {6'd0, rdf, fef, llf});
    t_rx_filter();
    t_rx_fill();
    t_tx_dbuf();
    t_tx_single();
    t_break();
    results();
  end

  // several times the expected length of the whole run
  initial begin
    #800000;
    err_total++;
    results();
  end
endmodule
